// [src/luhp_pkg.sv]
package luhp_pkg;
    // ==========================================
    // Geometry
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int REG_AW = 8;
    localparam int NUM_CHAN = 14;
    localparam int CHAN_REGS = 16;
    localparam int CHAN_SHIFT = 4;
    // ==========================================
    // Map
    localparam logic [7:0] GLOBAL_LO = 8'he0;
    localparam logic [7:0] GLOBAL_HI = 8'heb;
    localparam logic [7:0] RSVD_A_LO = 8'hec;
    localparam logic [7:0] RSVD_A_HI = 8'hed;
    localparam logic [7:0] RCLK_OUT_ADDR = 8'hee;
    localparam logic [7:0] RSVD_B_LO = 8'hef;
    localparam logic [7:0] RSVD_B_HI = 8'hf3;
    localparam logic [7:0] GLOBAL_EXTRA_ADDR = 8'hf4;
    localparam logic [7:0] TEST_LO = 8'hf5;
    localparam logic [7:0] TEST_HI = 8'hfd;
    localparam logic [7:0] DEVICE_IDENTIFIER_ADDR = 8'hfe;
    localparam logic [7:0] REVISION_ID_ADDR = 8'hff;
    localparam logic [3:0] CHAN_PATTERN_RX_EQ = 4'h0;
    localparam logic [3:0] CHAN_TERMINATION_JITTER = 4'h1;
    localparam logic [3:0] CHAN_TX_TEST_LOOPBACK = 4'h2;
    localparam logic [3:0] CHAN_CODE_ERROR_INSERT = 4'h3;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Register three bits 7, 6 and 0 read zero
    localparam logic [7:0] REG3_MASK = 8'h3e;
    // Arbitrary identification values
    localparam logic [7:0] DEVICE_IDENTIFIER_DEF = 8'h5a;
    localparam logic [7:0] REVISION_ID_DEF = 8'h01;
    // ==========================================
    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int ACK_MAX_NS = 90;
    localparam int ACK_MAX_CYC = ACK_MAX_NS / CLK_PERIOD_NS;
    // ==========================================
    // Handshake states
    typedef enum logic [1:0] {
        LUHP_IDLE = 2'b00,
        LUHP_ACK = 2'b01,
        LUHP_HOLD = 2'b10
    } luhp_state_t;
endpackage : luhp_pkg

// [src/luhp_regmem.sv]
`timescale 1ns/1ps
module luhp_regmem #(
    parameter int AW = 8,
    parameter int DW = 8,
    parameter int DEPTH = 224
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    // ==========================================
    // Storage; reset so every field has a known value
    logic [DW-1:0] mem_r [DEPTH];

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_word
            always_ff @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                    mem_r[gi] <= luhp_pkg::REG_RESET;
                else if (ce && wr_en && (wr_addr == AW'(gi)))
                    mem_r[gi] <= wr_data;
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rd_data <= luhp_pkg::REG_RESET;
        else if (ce)
            rd_data <= (int'(rd_addr) < DEPTH) ? mem_r[rd_addr] : luhp_pkg::REG_RESET;
    end
endmodule : luhp_regmem

// [src/luhp_host_port.sv]
`timescale 1ns/1ps
module luhp_host_port #(
    parameter logic [7:0] DEVICE_IDENTIFIER = luhp_pkg::DEVICE_IDENTIFIER_DEF,
    parameter logic [7:0] REVISION_ID = luhp_pkg::REVISION_ID_DEF
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [luhp_pkg::ADDR_W-1:0] addr,
    input wire logic cs_n,
    input wire logic rd_wr_n,
    input wire logic we_n,
    input wire logic [luhp_pkg::DATA_W-1:0] data_in,
    output logic [luhp_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    output logic xfer_done_n,
    output logic [luhp_pkg::NUM_CHAN*luhp_pkg::DATA_W-1:0] chan_reg0,
    output logic [luhp_pkg::NUM_CHAN*luhp_pkg::DATA_W-1:0] chan_reg1,
    output logic [luhp_pkg::NUM_CHAN*luhp_pkg::DATA_W-1:0] chan_reg2,
    output logic [luhp_pkg::NUM_CHAN*luhp_pkg::DATA_W-1:0] chan_reg3,
    output logic [luhp_pkg::DATA_W-1:0] recovered_clock_output,
    output logic [luhp_pkg::DATA_W-1:0] global_control_extra
);
    localparam int DW = luhp_pkg::DATA_W;
    localparam int NC = luhp_pkg::NUM_CHAN;
    localparam int CHAN_END = NC * luhp_pkg::CHAN_REGS;
    localparam int GLB_N = int'(luhp_pkg::GLOBAL_HI) - int'(luhp_pkg::GLOBAL_LO) + 1;
    localparam int ACK_LIM = luhp_pkg::ACK_MAX_CYC;

    // ==========================================
    // Decode
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    logic [7:0] reg_addr;
    logic is_chan;
    logic [3:0] chan_idx;
    logic [3:0] chan_off;
    logic is_global;
    logic is_storage;
    logic is_rsvd;
    assign reg_addr = addr[luhp_pkg::REG_AW-1:0];
    assign is_chan = int'(reg_addr) < CHAN_END;
    assign chan_idx = reg_addr[7:luhp_pkg::CHAN_SHIFT];
    assign chan_off = reg_addr[luhp_pkg::CHAN_SHIFT-1:0];
    assign is_global = in_range(reg_addr, luhp_pkg::GLOBAL_LO, luhp_pkg::GLOBAL_HI);
    assign is_storage = is_chan || is_global;
    assign is_rsvd = in_range(reg_addr, luhp_pkg::RSVD_A_LO, luhp_pkg::RSVD_A_HI)
        || in_range(reg_addr, luhp_pkg::RSVD_B_LO, luhp_pkg::RSVD_B_HI)
        || in_range(reg_addr, luhp_pkg::TEST_LO, luhp_pkg::TEST_HI);

    // ==========================================
    // Handshake
    luhp_pkg::luhp_state_t state_r;
    luhp_pkg::luhp_state_t state_nxt;
    logic start;
    logic wr_fire;
    logic wr_store;
    logic [DW-1:0] wr_val;
    // strobes sampled on mclk, synchronous mode
    // write when direction low and strobe low
    assign start = !cs_n && !we_n && (state_r == luhp_pkg::LUHP_IDLE);
    assign wr_fire = start && !rd_wr_n;
    // reserved, test and identity writes are dropped
    assign wr_store = wr_fire && is_storage;
    // reserved bits of register three stay zero
    assign wr_val = (is_chan && chan_off == luhp_pkg::CHAN_CODE_ERROR_INSERT)
        ? (data_in & luhp_pkg::REG3_MASK) : data_in;

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            luhp_pkg::LUHP_IDLE: if (start) state_nxt = luhp_pkg::LUHP_ACK;
            luhp_pkg::LUHP_ACK: state_nxt = luhp_pkg::LUHP_HOLD;
            // wait for host to release strobe or select
            luhp_pkg::LUHP_HOLD: if (cs_n || we_n) state_nxt = luhp_pkg::LUHP_IDLE;
            default: state_nxt = luhp_pkg::LUHP_IDLE;
        endcase
    end

    // ==========================================
    // Storage: channel blocks and globals
    logic [DW-1:0] mem_rd;
    luhp_regmem #(
        .AW(luhp_pkg::REG_AW),
        .DW(DW),
        .DEPTH(CHAN_END + GLB_N)
    ) u_mem (
        .mclk(mclk),
        .resetn(resetn),
        .ce(ce),
        .wr_en(wr_store),
        .wr_addr(reg_addr),
        .wr_data(wr_val),
        .rd_addr(reg_addr),
        .rd_data(mem_rd)
    );

    // Field copies kept in flops so the line logic sees them directly
    // per-channel field registers
    genvar gc;
    generate
        for (gc = 0; gc < NC; gc++)
        begin : g_chan
            logic hit;
            assign hit = wr_store && is_chan && (chan_idx == 4'(gc));
            always_ff @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                begin
                    chan_reg0[gc*DW +: DW] <= luhp_pkg::REG_RESET;
                    chan_reg1[gc*DW +: DW] <= luhp_pkg::REG_RESET;
                    chan_reg2[gc*DW +: DW] <= luhp_pkg::REG_RESET;
                    chan_reg3[gc*DW +: DW] <= luhp_pkg::REG_RESET;
                end
                else if (ce && hit)
                begin
                    if (chan_off == luhp_pkg::CHAN_PATTERN_RX_EQ)
                        chan_reg0[gc*DW +: DW] <= wr_val;
                    if (chan_off == luhp_pkg::CHAN_TERMINATION_JITTER)
                        chan_reg1[gc*DW +: DW] <= wr_val;
                    if (chan_off == luhp_pkg::CHAN_TX_TEST_LOOPBACK)
                        chan_reg2[gc*DW +: DW] <= wr_val;
                    if (chan_off == luhp_pkg::CHAN_CODE_ERROR_INSERT)
                        chan_reg3[gc*DW +: DW] <= wr_val;
                end
            end
        end
    endgenerate

    // ==========================================
    // Read mux; registered output of memory is used one cycle after start
    logic [7:0] addr_q_r;
    logic [DW-1:0] rd_mux;
    assign rd_mux = (int'(addr_q_r) < CHAN_END + GLB_N) ? mem_rd
        : (addr_q_r == luhp_pkg::RCLK_OUT_ADDR) ? recovered_clock_output
        : (addr_q_r == luhp_pkg::GLOBAL_EXTRA_ADDR) ? global_control_extra
        : (addr_q_r == luhp_pkg::DEVICE_IDENTIFIER_ADDR) ? DEVICE_IDENTIFIER
        : (addr_q_r == luhp_pkg::REVISION_ID_ADDR) ? REVISION_ID
        : luhp_pkg::REG_RESET;

    logic is_read_r;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= luhp_pkg::LUHP_IDLE;
            xfer_done_n <= 1'b1;
            addr_q_r <= luhp_pkg::REG_RESET;
            is_read_r <= 1'b0;
            data_out <= luhp_pkg::REG_RESET;
            data_oe <= 1'b0;
            recovered_clock_output <= luhp_pkg::REG_RESET;
            global_control_extra <= luhp_pkg::REG_RESET;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            // done low one cycle after the strobe is seen
            xfer_done_n <= !(state_nxt == luhp_pkg::LUHP_ACK
                || state_nxt == luhp_pkg::LUHP_HOLD);
            if (start)
            begin
                addr_q_r <= reg_addr;
                is_read_r <= rd_wr_n;
            end
            if (state_r == luhp_pkg::LUHP_ACK && is_read_r)
            begin
                data_out <= rd_mux;
                data_oe <= 1'b1;
            end
            else if (state_nxt == luhp_pkg::LUHP_IDLE)
                data_oe <= 1'b0;
            if (wr_fire && reg_addr == luhp_pkg::RCLK_OUT_ADDR)
                recovered_clock_output <= data_in;
            if (wr_fire && reg_addr == luhp_pkg::GLOBAL_EXTRA_ADDR)
                global_control_extra <= data_in;
        end
    end

    // ==========================================
    // Checks
    a_done_follows_write: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && wr_fire) |=> !xfer_done_n)
        else $error("done not asserted after write strobe");
    a_done_within_limit: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && start) |-> ##[1:ACK_LIM] !xfer_done_n)
        else $error("done later than limit");
    a_chan_store: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && wr_store && chan_idx == 4'h0 && chan_off == luhp_pkg::CHAN_PATTERN_RX_EQ)
        |=> chan_reg0[DW-1:0] == $past(data_in))
        else $error("channel zero register not stored");
    a_reg3_reserved: assert property (@(posedge mclk) disable iff (!resetn)
        (chan_reg3[DW-1:0] & ~luhp_pkg::REG3_MASK) == 8'h00)
        else $error("reserved bits of register three set");
    a_rsvd_no_store: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && wr_fire && is_rsvd) |=> ($stable(recovered_clock_output)
        && $stable(global_control_extra) && $stable(chan_reg0)))
        else $error("reserved write altered state");
    a_id_readback: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && start && rd_wr_n && reg_addr == luhp_pkg::DEVICE_IDENTIFIER_ADDR) ##1 ce
        |=> data_out == DEVICE_IDENTIFIER)
        else $error("device identity not returned");
    a_global_store: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && wr_fire && reg_addr == luhp_pkg::GLOBAL_EXTRA_ADDR)
        |=> global_control_extra == $past(data_in))
        else $error("global register not stored");
    a_hold_release: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && state_r == luhp_pkg::LUHP_HOLD && (cs_n || we_n)) |=> xfer_done_n)
        else $error("done not released");
endmodule : luhp_host_port

// [verification/luhp_host_model.sv]
`timescale 1ns/1ps
// ==========================================
// Host processor model
module luhp_host_model (
    input wire logic mclk,
    output logic [luhp_pkg::ADDR_W-1:0] addr,
    output logic cs_n,
    output logic rd_wr_n,
    output logic we_n,
    output logic [luhp_pkg::DATA_W-1:0] data_in,
    input wire logic xfer_done_n
);
    initial
    begin
        addr = 11'h7ff;
        cs_n = 1'b1;
        rd_wr_n = 1'b1;
        we_n = 1'b1;
        data_in = 8'h00;
    end

    // One access; n counts edges until done is seen
    task automatic access(input logic wr, input logic [10:0] a, input logic [7:0] d,
        output int n);
        @(negedge mclk);
        addr = a;
        cs_n = 1'b0;
        rd_wr_n = ~wr;
        data_in = d;
        we_n = 1'b0;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end while (xfer_done_n !== 1'b1 ? 1'b0 : n < 40);
        // Extra edge so read data has settled
        @(posedge mclk);
        @(negedge mclk);
        cs_n = 1'b1;
        we_n = 1'b1;
        rd_wr_n = 1'b1;
        // Released bus shows inverse, not stale value
        data_in = ~d;
        addr = ~a;
        repeat (2) @(posedge mclk);
    endtask : access
endmodule : luhp_host_model

// [verification/tb_line_unit_host_register_port.sv]
`timescale 1ns/1ps
module tb_line_unit_host_register_port;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    wire logic [10:0] addr;
    wire logic cs_n, rd_wr_n, we_n, data_oe, done_n;
    wire logic [7:0] data_in, data_out, rco, gce;
    wire logic [111:0] cr [4];
    int n_errors = 0;
    int n_compared = 0;
    int seed = 27;
    logic oe_seen = 1'b0;
    logic [7:0] exp_q [$];
    logic [7:0] mem [256];

    always #2 mclk = ~mclk;

    luhp_host_model host (.mclk(mclk), .addr(addr), .cs_n(cs_n), .rd_wr_n(rd_wr_n),
        .we_n(we_n), .data_in(data_in), .xfer_done_n(done_n));
    luhp_host_port dut (.mclk(mclk), .resetn(resetn), .ce(ce), .addr(addr), .cs_n(cs_n),
        .rd_wr_n(rd_wr_n), .we_n(we_n), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .xfer_done_n(done_n), .chan_reg0(cr[0]), .chan_reg1(cr[1]),
        .chan_reg2(cr[2]), .chan_reg3(cr[3]), .recovered_clock_output(rco),
        .global_control_extra(gce));

    task automatic check(input logic [111:0] seen, input logic [111:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    // Upper address bits random; they must not matter
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        host.access(wr, {3'($random(seed)), a}, d, n);
        // Done within 90 ns of strobe
        check(112'(n * 4 - 2 <= luhp_pkg::ACK_MAX_NS), 112'h1);
        // Done and drive released after host lets go
        check({done_n, data_oe}, 112'h2);
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
        if (a < 8'he0 || a <= 8'heb || a == 8'hee || a == 8'hf4)
            mem[a] = (a < 8'he0 && a[3:0] == 4'h3) ? d & luhp_pkg::REG3_MASK : d;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        exp_q.push_back(mem[a]);
        acc(1'b0, a, 8'($random(seed)));
    endtask : rd

    task automatic check_all();
        for (int ch = 0; ch < 14; ch++)
            for (int r = 0; r < 4; r++)
                check(112'(cr[r][ch*8+:8]), 112'(mem[ch*16+r]));
        check({rco, gce}, {mem[8'hee], mem[8'hf4]});
    endtask : check_all

    // Read data compared at its first valid cycle
    always @(negedge mclk)
    begin
        if (data_oe === 1'b1 && !oe_seen)
            check(112'(data_out), 112'(exp_q.pop_front()));
        oe_seen = (data_oe === 1'b1);
    end

    initial
    begin
        #100000;
        n_errors++;
        results();
    end

    initial
    begin
        foreach (mem[i])
            mem[i] = 8'h00;
        mem[8'hfe] = luhp_pkg::DEVICE_IDENTIFIER_DEF;
        mem[8'hff] = luhp_pkg::REVISION_ID_DEF;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        resetn = 1'b1;
        check({done_n, data_oe}, 112'h2);
        check_all();
        // Every channel block, back to back
        for (int ch = 0; ch < 14; ch++)
            for (int r = 0; r < 4; r++)
            begin
                wr(8'(ch * 16 + r), 8'($random(seed)));
                rd(8'(ch * 16 + r));
            end
        // Globals and the two extra registers
        for (int a = 8'he0; a <= 8'hf4; a++)
            if (a <= 8'heb || a == 8'hee || a == 8'hf4)
            begin
                wr(8'(a), 8'($random(seed)));
                rd(8'(a));
            end
        check_all();
        // Reserved, test and identity writes ignored
        for (int a = 8'hec; a <= 8'hff; a++)
            if (a != 8'hee && a != 8'hf4)
            begin
                wr(8'(a), 8'($random(seed)));
                rd(8'(a));
            end
        rd(8'hfe);
        rd(8'hff);
        check_all();
        // Frozen clock enable holds a pending request
        @(negedge mclk);
        ce = 1'b0;
        fork
            wr(8'h05 + 8'h0d, 8'ha5);
            begin
                repeat (5) @(posedge mclk);
                check(112'(done_n), 112'h1);
                @(negedge mclk);
                ce = 1'b1;
            end
        join
        check_all();
        // Mid-run reset clears every writable register
        @(negedge mclk);
        resetn = 1'b0;
        @(negedge mclk);
        resetn = 1'b1;
        for (int a = 0; a < 8'hfe; a++)
            mem[a] = luhp_pkg::REG_RESET;
        check({done_n, data_oe}, 112'h2);
        check_all();
        rd(8'h12);
        rd(8'he5);
        check(112'(exp_q.size()), 112'h0);
        results();
    end
endmodule : tb_line_unit_host_register_port
